// >>> hdl/orrot_alu.sv
// Combinational result logic for OR, rotate and bit-clear operations
`timescale 1ns/10ps
`include "orrot_consts.svh"
module orrot_alu (
  // Operation
  input wire orrot_pkg::orrot_op_t op,
  input wire logic [2:0] bit_sel,
  // Operands
  input wire logic [`ORROT_DATA_W-1:0] acc,
  input wire logic [`ORROT_DATA_W-1:0] mem,
  input wire logic [`ORROT_DATA_W-1:0] imm,
  input wire logic cf,
  input wire logic zf,
  // Result
  output orrot_pkg::orrot_alu_res_t res
);
  function automatic logic [`ORROT_DATA_W-1:0] rot_l(input logic [`ORROT_DATA_W-1:0] v, input logic fill);
    rot_l = {v[`ORROT_MSB-1:`ORROT_LSB], fill};
  endfunction

  function automatic logic [`ORROT_DATA_W-1:0] rot_r(input logic [`ORROT_DATA_W-1:0] v, input logic fill);
    rot_r = {fill, v[`ORROT_MSB:`ORROT_LSB+1]};
  endfunction

  logic [`ORROT_DATA_W-1:0] or_acc;
  logic [`ORROT_DATA_W-1:0] bit_mask;

  always_comb begin
    or_acc = acc | mem;
    bit_mask = ~(`ORROT_DATA_W'(1) << bit_sel);
    res.acc_we = 1'b0;
    res.acc = acc;
    res.mem_we = 1'b0;
    res.mem = mem;
    res.cf = cf;
    res.zf = zf;
    case (op)
      orrot_pkg::ORROT_OP_OR_MEM: begin
        res.acc_we = 1'b1;
        res.acc = or_acc;
        res.zf = (or_acc == `ORROT_BYTE_ZERO);
      end
      orrot_pkg::ORROT_OP_OR_IMM: begin
        res.acc_we = 1'b1;
        res.acc = acc | imm;
        res.zf = ((acc | imm) == `ORROT_BYTE_ZERO);
      end
      orrot_pkg::ORROT_OP_OR_INTO_MEMORY: begin
        res.mem_we = 1'b1;
        res.mem = or_acc;
        res.zf = (or_acc == `ORROT_BYTE_ZERO);
      end
      orrot_pkg::ORROT_OP_ROTATE_LEFT_IN_PLACE: begin
        res.mem_we = 1'b1;
        res.mem = rot_l(mem, mem[`ORROT_MSB]);
      end
      orrot_pkg::ORROT_OP_ROTATE_LEFT_TO_ACC: begin
        res.acc_we = 1'b1;
        res.acc = rot_l(mem, mem[`ORROT_MSB]);
      end
      orrot_pkg::ORROT_OP_ROTATE_LEFT_THROUGH_CF: begin
        res.mem_we = 1'b1;
        res.mem = rot_l(mem, cf);
        res.cf = mem[`ORROT_MSB];
      end
      orrot_pkg::ORROT_OP_ROTATE_LEFT_CF_TO_ACC: begin
        res.acc_we = 1'b1;
        res.acc = rot_l(mem, cf);
        res.cf = mem[`ORROT_MSB];
      end
      orrot_pkg::ORROT_OP_ROTATE_RIGHT_IN_PLACE: begin
        res.mem_we = 1'b1;
        res.mem = rot_r(mem, mem[`ORROT_LSB]);
      end
      orrot_pkg::ORROT_OP_ROTATE_RIGHT_TO_ACC: begin
        res.acc_we = 1'b1;
        res.acc = rot_r(mem, mem[`ORROT_LSB]);
      end
      orrot_pkg::ORROT_OP_ROTATE_RIGHT_THROUGH_CF: begin
        res.mem_we = 1'b1;
        res.mem = rot_r(mem, cf);
        res.cf = mem[`ORROT_LSB];
      end
      orrot_pkg::ORROT_OP_BIT_CLEAR: begin
        res.mem_we = 1'b1;
        res.mem = mem & bit_mask;
      end
      orrot_pkg::ORROT_OP_RET_IMM: begin
        res.acc_we = 1'b1;
        res.acc = imm;
      end
      default: begin
        res.acc_we = 1'b0;
      end
    endcase
  end
endmodule

// >>> hdl/orrot_core.sv
// Execution core for OR, return, rotate and bit-clear instructions
//
// Overview of operation
// - No-operation changes nothing, just advances.
// - OR memory into accumulator, update zero.
// - OR immediate into accumulator, update zero.
// - OR accumulator into memory, zero only.
// - Subroutine exit pops PC, flags untouched.
// - Return also loads immediate into accumulator.
// - Interrupt exit pops PC, sets master enable.
// - Pending interrupt served before resuming program.
// - Rotate memory left in place, no flags.
// - Left rotation into accumulator, memory kept.
// - Left through carry, stored to memory.
// - Left through carry into accumulator, carry updated.
// - Rotate memory right in place, no flags.
// - Right rotation into accumulator, memory kept.
// - Right through carry, stored to memory.
// - Bit clear zeroes one memory bit.
`timescale 1ns/10ps
`include "orrot_consts.svh"
module orrot_core #(
  parameter int STACK_DEPTH = `ORROT_STACK_DEPTH,
  parameter logic [`ORROT_PC_W-1:0] IRQ_VECTOR = `ORROT_IRQ_VECTOR
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Instruction issue
  input wire orrot_pkg::orrot_instr_t instr,
  output logic instr_ready,
  // Data memory
  input wire logic [`ORROT_DATA_W-1:0] mem_rd_data,
  output orrot_pkg::orrot_memwr_t mem_wr,
  // Interrupt
  input wire logic irq_pending,
  input wire logic mie_set,
  output logic irq_ack,
  // Architectural state
  output logic [`ORROT_PC_W-1:0] pc,
  output logic [`ORROT_DATA_W-1:0] acc,
  output logic carry_flag,
  output logic zero_flag,
  output logic master_interrupt_enable,
  output logic [$clog2(STACK_DEPTH)-1:0] stack_level
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  orrot_pkg::orrot_state_t state_q, state_d;
  logic [`ORROT_PC_W-1:0] pc_q, pc_d;
  logic [`ORROT_PC_W-1:0] stack_q [STACK_DEPTH];
  logic [`ORROT_PC_W-1:0] stack_d [STACK_DEPTH];
  logic [SP_W-1:0] sp_q, sp_d;
  logic [`ORROT_DATA_W-1:0] acc_q, acc_d;
  logic cf_q, cf_d;
  logic zf_q, zf_d;
  logic mie_q, mie_d;
  logic ack_q, ack_d;
  orrot_pkg::orrot_memwr_t memwr_q, memwr_d;
  orrot_pkg::orrot_alu_res_t alu_res;
  logic [`ORROT_DATA_W-1:0] mem_operand;
  logic irq_take;
  logic take;
  logic [SP_W-1:0] sp_top;

  // Address of the instruction after the one now taken
  function automatic logic [`ORROT_PC_W-1:0] pc_next(input logic [`ORROT_PC_W-1:0] p);
    pc_next = p + `ORROT_PC_STEP;
  endfunction

  // Stack pointer moves wrap silently; no overflow trap in this block
  function automatic logic [SP_W-1:0] sp_push(input logic [SP_W-1:0] s);
    sp_push = s + SP_W'(1);
  endfunction

  function automatic logic [SP_W-1:0] sp_pop(input logic [SP_W-1:0] s);
    sp_pop = s - SP_W'(1);
  endfunction

  // Forward last write; the external memory lands it only at the next edge
  always_comb begin
    if (memwr_q.we && (memwr_q.addr == instr.addr)) begin
      mem_operand = memwr_q.data;
    end else begin
      mem_operand = mem_rd_data;
    end
  end

  orrot_alu u_alu (
    .op(instr.op),
    .bit_sel(instr.bit_sel),
    .acc(acc_q),
    .mem(mem_operand),
    .imm(instr.imm),
    .cf(cf_q),
    .zf(zf_q),
    .res(alu_res)
  );

  // Interrupt entry only at an instruction boundary, never during a dummy cycle
  assign irq_take = (state_q == orrot_pkg::ORROT_ST_RUN) && mie_q && irq_pending;
  assign instr_ready = (state_q == orrot_pkg::ORROT_ST_RUN) && !irq_take;
  assign take = instr_ready && instr.valid;
  assign sp_top = sp_pop(sp_q);

  // Flow group: sequencing, program counter, return stack and master enable
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    stack_d = stack_q;
    sp_d = sp_q;
    mie_d = mie_q | mie_set;
    case (state_q)
      orrot_pkg::ORROT_ST_RUN: begin
        if (irq_take) begin
          stack_d[sp_q] = pc_q;
          sp_d = sp_push(sp_q);
          pc_d = IRQ_VECTOR;
          mie_d = 1'b0;
          state_d = orrot_pkg::ORROT_ST_DUMMY;
        end else if (take) begin
          pc_d = pc_next(pc_q);
          case (instr.op)
            orrot_pkg::ORROT_OP_SUBROUTINE_EXIT, orrot_pkg::ORROT_OP_RET_IMM: begin
              pc_d = stack_q[sp_top];
              sp_d = sp_top;
              state_d = orrot_pkg::ORROT_ST_DUMMY;
            end
            orrot_pkg::ORROT_OP_INTERRUPT_EXIT: begin
              pc_d = stack_q[sp_top];
              sp_d = sp_top;
              mie_d = 1'b1;
              state_d = orrot_pkg::ORROT_ST_DUMMY;
            end
            orrot_pkg::ORROT_OP_CALL: begin
              stack_d[sp_q] = pc_next(pc_q);
              sp_d = sp_push(sp_q);
              pc_d = instr.target;
              state_d = orrot_pkg::ORROT_ST_DUMMY;
            end
            default: begin
              state_d = orrot_pkg::ORROT_ST_RUN;
            end
          endcase
        end
      end
      orrot_pkg::ORROT_ST_DUMMY: begin
        // Dummy cycle while the new fetch address settles
        state_d = orrot_pkg::ORROT_ST_RUN;
      end
      default: begin
        state_d = orrot_pkg::ORROT_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= orrot_pkg::ORROT_ST_RUN;
      pc_q <= `ORROT_PC_RESET;
      sp_q <= '0;
      mie_q <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_q[i] <= `ORROT_PC_RESET;
      end
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      mie_q <= mie_d;
      stack_q <= stack_d;
    end
  end

  // Datapath group: results land only when an instruction is really taken
  always_comb begin
    acc_d = acc_q;
    cf_d = cf_q;
    zf_d = zf_q;
    memwr_d = '0;
    if (take) begin
      if (alu_res.acc_we) begin
        acc_d = alu_res.acc;
      end
      cf_d = alu_res.cf;
      zf_d = alu_res.zf;
      memwr_d.we = alu_res.mem_we;
      memwr_d.addr = instr.addr;
      memwr_d.data = alu_res.mem;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_q <= `ORROT_BYTE_ZERO;
      cf_q <= 1'b0;
      zf_q <= 1'b0;
      memwr_q <= '0;
    end else begin
      acc_q <= acc_d;
      cf_q <= cf_d;
      zf_q <= zf_d;
      memwr_q <= memwr_d;
    end
  end

  // Acknowledge group: one-cycle pulse after interrupt entry
  always_comb begin
    ack_d = irq_take;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  assign mem_wr = memwr_q;
  assign irq_ack = ack_q;
  assign pc = pc_q;
  assign acc = acc_q;
  assign carry_flag = cf_q;
  assign zero_flag = zf_q;
  assign master_interrupt_enable = mie_q;
  assign stack_level = sp_q;
endmodule

// >>> pkg/orrot_consts.svh
// Constants for the OR, return and rotate execution block
`ifndef ORROT_CONSTS_SVH
`define ORROT_CONSTS_SVH
`define ORROT_DATA_W 8
`define ORROT_ADDR_W 8
`define ORROT_PC_W 13
`define ORROT_STACK_DEPTH 8
`define ORROT_PC_RESET 13'h0000
`define ORROT_IRQ_VECTOR 13'h0004
`define ORROT_PC_STEP 13'h0001
`define ORROT_BYTE_ZERO 8'h00
`define ORROT_MSB 7
`define ORROT_LSB 0
`endif

// >>> pkg/orrot_pkg.sv
// Types shared by the OR, return and rotate execution block
`include "orrot_consts.svh"
package orrot_pkg;
  typedef enum logic [4:0] {
    ORROT_OP_NOP,
    ORROT_OP_OR_MEM,
    ORROT_OP_OR_IMM,
    ORROT_OP_OR_INTO_MEMORY,
    ORROT_OP_SUBROUTINE_EXIT,
    ORROT_OP_RET_IMM,
    ORROT_OP_INTERRUPT_EXIT,
    ORROT_OP_ROTATE_LEFT_IN_PLACE,
    ORROT_OP_ROTATE_LEFT_TO_ACC,
    ORROT_OP_ROTATE_LEFT_THROUGH_CF,
    ORROT_OP_ROTATE_LEFT_CF_TO_ACC,
    ORROT_OP_ROTATE_RIGHT_IN_PLACE,
    ORROT_OP_ROTATE_RIGHT_TO_ACC,
    ORROT_OP_ROTATE_RIGHT_THROUGH_CF,
    ORROT_OP_BIT_CLEAR,
    ORROT_OP_CALL
  } orrot_op_t;

  typedef enum logic {
    ORROT_ST_RUN,
    ORROT_ST_DUMMY
  } orrot_state_t;

  typedef struct packed {
    logic valid;
    orrot_op_t op;
    logic [`ORROT_ADDR_W-1:0] addr;
    logic [`ORROT_DATA_W-1:0] imm;
    logic [2:0] bit_sel;
    logic [`ORROT_PC_W-1:0] target;
  } orrot_instr_t;

  typedef struct packed {
    logic we;
    logic [`ORROT_ADDR_W-1:0] addr;
    logic [`ORROT_DATA_W-1:0] data;
  } orrot_memwr_t;

  typedef struct packed {
    logic acc_we;
    logic [`ORROT_DATA_W-1:0] acc;
    logic mem_we;
    logic [`ORROT_DATA_W-1:0] mem;
    logic cf;
    logic zf;
  } orrot_alu_res_t;
endpackage

// >>> tb/or_return_rotate_ops_bench.sv
// Random and directed bench for the OR, return and rotate core
`timescale 1ns/10ps
`include "orrot_consts.svh"
module or_return_rotate_ops_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic irq_pending = 1'b0;
  logic mie_set = 1'b0;
  logic instr_ready, irq_ack, carry_flag, zero_flag, master_interrupt_enable, e_cf, e_zf, e_mie;
  orrot_pkg::orrot_instr_t instr = '0;
  orrot_pkg::orrot_memwr_t mem_wr;
  logic [7:0] mem_rd_data, acc, e_acc;
  logic [7:0] rnd = 8'h2E;
  logic [7:0] mem [256];
  logic [7:0] em [256];
  logic [12:0] pc, e_pc;
  logic [12:0] stk [$];
  logic [2:0] stack_level;
  int failures = 0;
  int compares = 0;
  int k;
  always #50 clk_sys = ~clk_sys;
  assign mem_rd_data = mem[instr.addr];
  always @(posedge clk_sys)
    if (mem_wr.we) mem[mem_wr.addr] <= mem_wr.data;
  orrot_core dut_u (.clk_sys(clk_sys), .rst(rst), .instr(instr), .instr_ready(instr_ready),
    .mem_rd_data(mem_rd_data), .mem_wr(mem_wr), .irq_pending(irq_pending), .mie_set(mie_set), .irq_ack(irq_ack),
    .pc(pc), .acc(acc), .carry_flag(carry_flag), .zero_flag(zero_flag),
    .master_interrupt_enable(master_interrupt_enable), .stack_level(stack_level));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Expected one-place rotation, with the bit that enters at the free end
  function automatic logic [7:0] rot8(input logic [7:0] m, input logic left, input logic fill);
    return left ? {m[6:0], fill} : {fill, m[7:1]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Issue one op, hold it until taken, then compare against the model
  task automatic run(input orrot_pkg::orrot_op_t op, input logic [7:0] a, input logic [7:0] x);
    logic [7:0] m;
    logic fl;
    int n;
    fl = 1'b0;
    n = 0;
    @(posedge clk_sys);
    instr <= '{1'b1, op, a, x, x[2:0], {5'h00, x}};
    @(negedge clk_sys);
    while (instr_ready !== 1'b1 && n < 9) begin
      @(negedge clk_sys);
      n++;
    end
    m = em[a];
    e_pc = e_pc + 13'h0001;
    case (op)
      orrot_pkg::ORROT_OP_OR_MEM: e_acc = e_acc | m;
      orrot_pkg::ORROT_OP_OR_IMM: e_acc = e_acc | x;
      orrot_pkg::ORROT_OP_OR_INTO_MEMORY: em[a] = e_acc | m;
      orrot_pkg::ORROT_OP_SUBROUTINE_EXIT: e_pc = stk.pop_back();
      orrot_pkg::ORROT_OP_RET_IMM: e_pc = stk.pop_back();
      orrot_pkg::ORROT_OP_INTERRUPT_EXIT: e_pc = stk.pop_back();
      orrot_pkg::ORROT_OP_ROTATE_LEFT_IN_PLACE: em[a] = rot8(m, 1'b1, m[7]);
      orrot_pkg::ORROT_OP_ROTATE_LEFT_TO_ACC: e_acc = rot8(m, 1'b1, m[7]);
      orrot_pkg::ORROT_OP_ROTATE_LEFT_THROUGH_CF: em[a] = rot8(m, 1'b1, e_cf);
      orrot_pkg::ORROT_OP_ROTATE_LEFT_CF_TO_ACC: e_acc = rot8(m, 1'b1, e_cf);
      orrot_pkg::ORROT_OP_ROTATE_RIGHT_IN_PLACE: em[a] = rot8(m, 1'b0, m[0]);
      orrot_pkg::ORROT_OP_ROTATE_RIGHT_TO_ACC: e_acc = rot8(m, 1'b0, m[0]);
      orrot_pkg::ORROT_OP_ROTATE_RIGHT_THROUGH_CF: em[a] = rot8(m, 1'b0, e_cf);
      orrot_pkg::ORROT_OP_BIT_CLEAR: em[a][x[2:0]] = 1'b0;
      orrot_pkg::ORROT_OP_CALL: stk.push_back(e_pc);
      default: ;
    endcase
    // Flag, accumulator and PC side effects, by operation number
    if (op <= 2 && op > 0) e_zf = (op == 3) ? em[a] == 8'h00 : e_acc == 8'h00;
    if (op == 3) e_zf = em[a] == 8'h00;
    if (op == 9 || op == 10) e_cf = m[7];
    if (op == 13) e_cf = m[0];
    if (op == 5) e_acc = x;
    if (op == 6) e_mie = 1'b1;
    if (op == 15) e_pc = {5'h00, x};
    fl = op inside {5'd4, 5'd5, 5'd6, 5'd15};
    @(posedge clk_sys);
    instr.valid <= 1'b0;
    @(negedge clk_sys);
    chk(acc, e_acc);
    chk({pc, carry_flag, zero_flag, master_interrupt_enable}, {e_pc, e_cf, e_zf, e_mie});
    chk({instr_ready, stack_level}, {!fl, 3'(stk.size())});
    @(negedge clk_sys);
    chk(mem[a], em[a]);
  endtask
  initial begin
    {e_acc, e_cf, e_zf, e_mie, e_pc} = '0;
    for (int i = 0; i < 256; i++) begin
      rnd = lfsr(rnd);
      mem[i] = i ? rnd : 8'h00;
      em[i] = mem[i];
    end
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk({pc, acc, carry_flag, zero_flag, master_interrupt_enable, stack_level}, '0);
    run(orrot_pkg::ORROT_OP_OR_IMM, 8'h00, 8'h00);
    run(orrot_pkg::ORROT_OP_OR_MEM, 8'h00, 8'h00);
    run(orrot_pkg::ORROT_OP_CALL, 8'h01, 8'h40);
    run(orrot_pkg::ORROT_OP_CALL, 8'h01, 8'h80);
    run(orrot_pkg::ORROT_OP_RET_IMM, 8'h01, 8'h5A);
    run(orrot_pkg::ORROT_OP_SUBROUTINE_EXIT, 8'h01, 8'h00);
    // Moves the saved return address away from the interrupt vector
    run(orrot_pkg::ORROT_OP_NOP, 8'h01, 8'h00);
    run(orrot_pkg::ORROT_OP_CALL, 8'h01, 8'h20);
    @(posedge clk_sys);
    irq_pending <= 1'b1;
    run(orrot_pkg::ORROT_OP_INTERRUPT_EXIT, 8'h01, 8'h00);
    @(negedge clk_sys);
    stk.push_back(e_pc);
    e_pc = `ORROT_IRQ_VECTOR;
    e_mie = 1'b0;
    chk({irq_ack, pc, master_interrupt_enable, stack_level}, {1'b1, e_pc, e_mie, 3'(stk.size())});
    @(posedge clk_sys);
    irq_pending <= 1'b0;
    mie_set <= 1'b1;
    @(posedge clk_sys);
    mie_set <= 1'b0;
    @(negedge clk_sys);
    chk(master_interrupt_enable, 1'b1);
    run(orrot_pkg::ORROT_OP_INTERRUPT_EXIT, 8'h01, 8'h00);
    // Back to back on one byte: the second op must see the first one's write
    @(posedge clk_sys);
    instr <= '{1'b1, orrot_pkg::ORROT_OP_ROTATE_LEFT_IN_PLACE, 8'h02, 8'h00, 3'h0, 13'h0000};
    @(posedge clk_sys);
    instr.op <= orrot_pkg::ORROT_OP_ROTATE_LEFT_TO_ACC;
    @(posedge clk_sys);
    instr.valid <= 1'b0;
    em[2] = rot8(em[2], 1'b1, em[2][7]);
    e_acc = rot8(em[2], 1'b1, em[2][7]);
    e_pc = e_pc + 13'h0002;
    @(negedge clk_sys);
    chk({acc, pc}, {e_acc, e_pc});
    chk(mem[2], em[2]);
    // Random non-flow traffic on a small address window to force reuse
    repeat (200) begin
      rnd = lfsr(rnd);
      k = rnd % 12;
      run(orrot_pkg::orrot_op_t'(k < 4 ? k : k + 3), {4'h0, rnd[3:0]}, lfsr(rnd));
    end
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    stop_test();
  end
endmodule

// >>> tb/orrot_core_asserts.sv
// Concurrent checks on the OR, return and rotate core
`timescale 1ns/10ps
module orrot_core_asserts #(
  parameter int STACK_DEPTH = 8,
  parameter logic [12:0] IRQ_VECTOR = 13'h0004
) (
  // Clock, reset, issue
  input wire logic clk_sys,
  input wire logic rst,
  input wire orrot_pkg::orrot_instr_t instr,
  input wire logic instr_ready,
  input wire logic [7:0] mem_rd_data,
  input wire orrot_pkg::orrot_memwr_t mem_wr,
  input wire logic irq_pending,
  input wire logic mie_set,
  input wire logic irq_ack,
  // State
  input wire logic [12:0] pc,
  input wire logic [7:0] acc,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic master_interrupt_enable,
  input wire logic [$clog2(STACK_DEPTH)-1:0] stack_level
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic tk;
  logic c_q;
  logic [7:0] m_q;
  orrot_pkg::orrot_op_t o;
  assign tk = instr.valid && instr_ready;
  assign o = instr.op;
  // Operand snapshot; a byte still on its way to memory is the newer one
  always_ff @(posedge clk_sys) begin
    m_q <= (mem_wr.we && mem_wr.addr == instr.addr) ? mem_wr.data : mem_rd_data;
    c_q <= carry_flag;
  end
  chk_nop_idle:
    assert property (tk && o == orrot_pkg::ORROT_OP_NOP |=> pc == $past(pc) + 13'h0001 && acc == $past(acc))
    else $error("nop changed state");
  chk_or_acc:
    assert property (tk && o == orrot_pkg::ORROT_OP_OR_MEM |=> acc == ($past(acc) | m_q) && zero_flag == (acc == 8'h00))
    else $error("or result wrong");
  chk_or_store:
    assert property (tk && o == orrot_pkg::ORROT_OP_OR_INTO_MEMORY |=> mem_wr.we && mem_wr.data == ($past(acc) | m_q))
    else $error("or store wrong");
  chk_ret_pop:
    assert property (tk && o inside {[orrot_pkg::ORROT_OP_SUBROUTINE_EXIT:orrot_pkg::ORROT_OP_INTERRUPT_EXIT]}
      |=> stack_level == $past(stack_level) - 1'b1 && !instr_ready)
    else $error("return pop wrong");
  chk_interrupt_exit_mie:
    assert property (tk && o == orrot_pkg::ORROT_OP_INTERRUPT_EXIT |=> master_interrupt_enable)
    else $error("enable not set");
  chk_interrupt_exit_irq:
    assert property (tk && o == orrot_pkg::ORROT_OP_INTERRUPT_EXIT ##1 irq_pending [*2] |=> irq_ack && pc == IRQ_VECTOR)
    else $error("pending irq skipped");
  chk_rlc_mem:
    assert property (tk && o == orrot_pkg::ORROT_OP_ROTATE_LEFT_THROUGH_CF
      |=> mem_wr.we && mem_wr.data == {m_q[6:0], c_q} && carry_flag == m_q[7])
    else $error("left carry rotate wrong");
  chk_rrc_mem:
    assert property (tk && o == orrot_pkg::ORROT_OP_ROTATE_RIGHT_THROUGH_CF
      |=> mem_wr.we && mem_wr.data == {c_q, m_q[7:1]} && carry_flag == m_q[0])
    else $error("right carry rotate wrong");
  cov_irq: cover property (irq_ack);
  cov_call: cover property (tk && o == orrot_pkg::ORROT_OP_CALL);
  cov_rrc: cover property (tk && o == orrot_pkg::ORROT_OP_ROTATE_RIGHT_THROUGH_CF);
endmodule
bind orrot_core orrot_core_asserts #(.STACK_DEPTH(STACK_DEPTH), .IRQ_VECTOR(IRQ_VECTOR)) chk_u (.clk_sys, .rst,
  .instr, .instr_ready, .mem_rd_data, .mem_wr, .irq_pending, .mie_set, .irq_ack, .pc, .acc, .carry_flag,
  .zero_flag, .master_interrupt_enable, .stack_level);
